// >>> src/area_attr_decode.sv
// Purpose: Turns an address and the three area registers into the area's access attributes.
// Assumes: Areas are the top three bits of a 24-bit address.
// Notes: Purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_params.svh"

module area_attr_decode
(
   input wire logic [23:0] addr_i,
   input wire logic [7:0] width_reg_i,
   input wire logic [7:0] state_reg_i,
   input wire logic [7:0] wait_reg_i,
   output var ext_bus_pkg::area_index_t area_o,
   output logic width8_o,
   output logic three_state_o,
   output logic [1:0] prog_waits_o
);

   logic [1:0] field_waits [0:7];

   // Areas 7 to 4 take their two-bit field; the lower four share a fixed count.
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_field
         if (g >= 4)
         begin : g_upper
            assign field_waits[g] = wait_reg_i[2*(g-4)+1 -: 2];
         end
         else
         begin : g_lower
            assign field_waits[g] = `EAB_LOWER_AREA_WAITS;
         end
      end
   endgenerate

   // Each area's bit or field applies to the address that falls inside it.
   assign area_o = addr_i[`EAB_ADDR_MSB:`EAB_AREA_LSB];
   assign width8_o = width_reg_i[area_o];
   assign three_state_o = state_reg_i[area_o];
   // A two-state area never gets program waits, whatever its field holds.
   assign prog_waits_o = three_state_o ? field_waits[area_o] : 2'h0;

endmodule : area_attr_decode
`default_nettype wire

// >>> src/ext_bus_params.svh
// Purpose: Offsets, field positions, reset values and timing counts for the external bus block.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes: Definitions only; included by its bare name.
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH

// Register byte offsets on the Wishbone slave.
`define EAB_OFS_WIDTH 4'h0
`define EAB_OFS_STATE 4'h4
`define EAB_OFS_WAIT 4'h8
`define EAB_OFS_STATUS 4'hC

// Reset values of the configuration registers.
`define EAB_RST_WIDTH 8'hFF
`define EAB_RST_STATE 8'hFF
`define EAB_RST_WAIT 8'hFF

// Program wait count used for areas 3 to 0, which have no wait field here.
`define EAB_LOWER_AREA_WAITS 2'h3

// Address field that selects one of eight 2-Mbyte areas.
`define EAB_ADDR_MSB 23
`define EAB_AREA_LSB 21

// Status register field positions.
`define EAB_ST_BUSY 7
`define EAB_ST_WAITREQ 6
`define EAB_ST_THREE 4
`define EAB_ST_WIDTH8 3
`define EAB_ST_AREA_LSB 0

// Clock period in ns; one external state lasts one clock.
`define EAB_CLK_PERIOD_NS 50

`endif

// >>> src/ext_bus_pkg.sv
// Purpose: Types shared by the external bus block.
// Assumes: Nothing beyond the params header.
// Notes: States of the external cycle sequencer.
package ext_bus_pkg;

   // One external bus cycle walks idle, first and second state; a three-state area adds any wait states and the third state.
   typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3} cycle_state_t;

   typedef logic [2:0] area_index_t;

endpackage : ext_bus_pkg

// >>> src/external_area_bus_config.sv
// Purpose: External bus cycle sequencer with per-area width, state count and program waits.
// Assumes: One clock state per external bus state; wait and read data pins are asynchronous.
// Notes: Registers reached over classic Wishbone; pin strobes are active low.
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_params.svh"

// How it works
// [R1] Address strobe low throughout every external cycle.
// [R2] Read strobe low only in read cycles.
// [R3] Upper write strobe when upper lane carries data.
// [R4] Lower write strobe when lower lane carries data.
// [R5] Wait request pin extends the current cycle.
// [R6] One width bit per area, one register.
// [R7] Width bit zero sixteen-bit, one eight-bit.
// [R8] State bit zero: two states, no waits.
// [R9] State bit one: three states, waits enabled.
// [R10] Two-bit wait fields for areas seven to four.
// [R11] Field value gives zero to three waits.
// [R12] Program waits only in three-state areas.
// [R13] Eight areas of two Mbytes each.
// [R14] Program waits first, then wait pin extension.
module external_area_bus_config
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic req_valid_i,
   input wire logic req_we_i,
   input wire logic req_size16_i,
   input wire logic [23:0] req_addr_i,
   input wire logic [15:0] req_wdata_i,
   output logic req_ready_o,
   output logic req_done_o,
   output logic [15:0] req_rdata_o,
   output logic [23:0] ext_addr_o,
   output logic [15:0] ext_data_o,
   input wire logic [15:0] ext_data_i,
   output logic ext_data_oe_n_o,
   output logic addr_valid_strobe_n_o,
   output logic read_strobe_n_o,
   output logic upper_byte_write_strobe_n_o,
   output logic lower_byte_write_strobe_n_o,
   input wire logic wait_request_n_i
);

   // Configuration registers.
   logic [7:0] area_bus_width_control;
   logic [7:0] area_access_state_control;
   logic [7:0] upper_areas_wait_control;

   // Cycle sequencer state and the attributes latched at request time.
   ext_bus_pkg::cycle_state_t state;
   ext_bus_pkg::cycle_state_t next_state;
   ext_bus_pkg::area_index_t area_q;
   logic width8_q;
   logic three_q;
   logic we_q;
   logic size16_q;
   logic second_q;
   logic [15:0] wdata_q;
   logic [1:0] pw_cnt;
   logic [1:0] waits_q;

   // Pin synchronisers and read capture.
   logic wait_meta;
   logic wait_sync;
   logic [15:0] rd_sample;
   logic fin_q;
   logic fin_first_q;
   logic fin_word_q;
   logic fin_hi_q;

   // Wires from the area decoder.
   ext_bus_pkg::area_index_t dec_area;
   logic dec_width8;
   logic dec_three;
   logic [1:0] dec_waits;

   // Places write data on the lanes for one phase of an access.
   function automatic logic [15:0] lane_data(input logic size16, input logic width8,
                                             input logic second, input logic [15:0] wdata);
      logic [7:0] byte_val;
      byte_val = (size16 && !second) ? wdata[15:8] : wdata[7:0];
      if (size16 && !width8)
      begin
         lane_data = wdata;
      end
      else
      begin
         lane_data = {byte_val, byte_val};
      end
   endfunction : lane_data

   // Attributes for any access come from the address's area.
   area_attr_decode u_decode
   (
      .addr_i(req_addr_i),
      .width_reg_i(area_bus_width_control),
      .state_reg_i(area_access_state_control),
      .wait_reg_i(upper_areas_wait_control),
      .area_o(dec_area),
      .width8_o(dec_width8),
      .three_state_o(dec_three),
      .prog_waits_o(dec_waits)
   );

   // Request, phase and lane decoding.
   wire take_req = req_valid_i && (state == ext_bus_pkg::ST_IDLE);
   wire wait_req = !wait_sync;
   wire last_state = (state == ext_bus_pkg::ST_T3) || (state == ext_bus_pkg::ST_T2 && !three_q);
   wire split_more = last_state && size16_q && width8_q && !second_q;
   wire both_lanes = size16_q && !width8_q;
   wire hi_lane = both_lanes || width8_q || !ext_addr_o[0];
   wire lo_lane = both_lanes || (!width8_q && ext_addr_o[0]);
   wire write_phase = we_q && (state == ext_bus_pkg::ST_T2 || state == ext_bus_pkg::ST_TW
                               || state == ext_bus_pkg::ST_T3);
   wire tw_exit = (pw_cnt <= 2'h1) && !wait_req;

   assign req_ready_o = (state == ext_bus_pkg::ST_IDLE);

   // Next state of the external cycle.
   always_comb
   begin
      next_state = state;
      unique case (state)
         ext_bus_pkg::ST_IDLE:
         begin
            if (req_valid_i)
            begin
               next_state = ext_bus_pkg::ST_T1;
            end
         end
         ext_bus_pkg::ST_T1:
         begin
            next_state = ext_bus_pkg::ST_T2;
         end
         ext_bus_pkg::ST_T2:
         begin
            if (!three_q)
            begin
               next_state = split_more ? ext_bus_pkg::ST_T1 : ext_bus_pkg::ST_IDLE; // [R8]
            end
            else if (pw_cnt != 2'h0 || wait_req)
            begin
               next_state = ext_bus_pkg::ST_TW; // [R9] [R5]
            end
            else
            begin
               next_state = ext_bus_pkg::ST_T3;
            end
         end
         ext_bus_pkg::ST_TW:
         begin
            // Program waits run down first; only then may the pin hold the cycle.
            if (tw_exit)
            begin
               next_state = ext_bus_pkg::ST_T3; // [R14]
            end
         end
         ext_bus_pkg::ST_T3:
         begin
            next_state = split_more ? ext_bus_pkg::ST_T1 : ext_bus_pkg::ST_IDLE;
         end
      endcase
   end

   // Sequencer state register.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= ext_bus_pkg::ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Latch the area attributes at request time, so a register write mid-cycle is harmless.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         area_q <= 3'h0;
         width8_q <= 1'b0;
         three_q <= 1'b0;
         we_q <= 1'b0;
         size16_q <= 1'b0;
         wdata_q <= 16'h0000;
         waits_q <= 2'h0;
      end
      else if (take_req)
      begin
         area_q <= dec_area; // [R13]
         width8_q <= dec_width8; // [R7]
         three_q <= dec_three;
         we_q <= req_we_i;
         size16_q <= req_size16_i;
         wdata_q <= req_wdata_i;
         waits_q <= dec_waits; // [R12]
      end
   end

   // Phase flag: a word to an eight-bit area runs as two byte cycles, even address first.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         second_q <= 1'b0;
      end
      else if (take_req)
      begin
         second_q <= 1'b0;
      end
      else if (split_more)
      begin
         second_q <= 1'b1; // [R7]
      end
   end

   // Program wait counter, loaded per phase and counted down in the wait state.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pw_cnt <= 2'h0;
      end
      else if (take_req)
      begin
         pw_cnt <= dec_waits; // [R11] [R12]
      end
      // The second byte phase of a split word is an access too, so it waits as long.
      else if (split_more)
      begin
         pw_cnt <= waits_q; // [R11]
      end
      else if (state == ext_bus_pkg::ST_TW && pw_cnt != 2'h0)
      begin
         pw_cnt <= pw_cnt - 2'h1;
      end
   end

   // Address and write data pins, loaded at the start of each phase.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ext_addr_o <= 24'h000000;
         ext_data_o <= 16'h0000;
      end
      else if (take_req)
      begin
         ext_addr_o <= req_addr_i;
         ext_data_o <= lane_data(req_size16_i, dec_width8, 1'b0, req_wdata_i);
      end
      else if (split_more)
      begin
         ext_addr_o <= {ext_addr_o[23:1], 1'b1};
         ext_data_o <= lane_data(size16_q, width8_q, 1'b1, wdata_q);
      end
   end

   // Strobes decode from the sequencer state; the bus is driven in every non-idle state of a write cycle.
   assign addr_valid_strobe_n_o = (state == ext_bus_pkg::ST_IDLE); // [R1]
   assign read_strobe_n_o = (state == ext_bus_pkg::ST_IDLE) || we_q; // [R2]
   assign upper_byte_write_strobe_n_o = !(write_phase && hi_lane); // [R3]
   assign lower_byte_write_strobe_n_o = !(write_phase && lo_lane); // [R4]
   assign ext_data_oe_n_o = !((state != ext_bus_pkg::ST_IDLE) && we_q);

   // Two-stage synchroniser for the asynchronous wait pin.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wait_meta <= 1'b1;
         wait_sync <= 1'b1;
      end
      else
      begin
         wait_meta <= wait_request_n_i; // [R5]
         wait_sync <= wait_meta;
      end
   end

   // Read data is sampled free-running; the copy taken one state later is the stable one.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_sample <= 16'h0000;
         fin_q <= 1'b0;
         fin_first_q <= 1'b0;
         fin_word_q <= 1'b0;
         fin_hi_q <= 1'b0;
      end
      else
      begin
         rd_sample <= ext_data_i;
         fin_q <= last_state;
         fin_first_q <= split_more;
         fin_word_q <= both_lanes;
         fin_hi_q <= hi_lane;
      end
   end

   // Assemble the answer and flag completion two clocks after the last state.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         req_rdata_o <= 16'h0000;
         req_done_o <= 1'b0;
      end
      else
      begin
         req_done_o <= fin_q && !fin_first_q;
         if (fin_q && fin_word_q)
         begin
            req_rdata_o <= rd_sample;
         end
         else if (fin_q && fin_first_q)
         begin
            req_rdata_o <= {(fin_hi_q ? rd_sample[15:8] : rd_sample[7:0]), 8'h00};
         end
         else if (fin_q && second_q)
         begin
            req_rdata_o[7:0] <= fin_hi_q ? rd_sample[15:8] : rd_sample[7:0];
         end
         else if (fin_q)
         begin
            req_rdata_o <= {8'h00, (fin_hi_q ? rd_sample[15:8] : rd_sample[7:0])};
         end
      end
   end

   // Wishbone decode: one word per register, answer one clock after the strobe.
   wire wb_req = wb_cyc_i && wb_stb_i;
   wire wb_wr = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
   wire sel_width = (wb_adr_i == `EAB_OFS_WIDTH);
   wire sel_state = (wb_adr_i == `EAB_OFS_STATE);
   wire sel_wait = (wb_adr_i == `EAB_OFS_WAIT);
   wire sel_status = (wb_adr_i == `EAB_OFS_STATUS);
   wire [7:0] status_val = {(state != ext_bus_pkg::ST_IDLE), wait_req, 1'b0,
                            three_q, width8_q, area_q};
   wire [7:0] rd_mux = sel_width ? area_bus_width_control :
                       sel_state ? area_access_state_control :
                       sel_wait ? upper_areas_wait_control :
                       sel_status ? status_val : 8'h00;

   // Bus answer; unmapped addresses read zero and ignore writes.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wb_req && !wb_ack_o;
         wb_dat_o <= {24'h000000, rd_mux};
      end
   end

   // Register writes take effect on the edge that sees the acknowledge.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         area_bus_width_control <= `EAB_RST_WIDTH;
         area_access_state_control <= `EAB_RST_STATE;
         upper_areas_wait_control <= `EAB_RST_WAIT;
      end
      else if (wb_wr)
      begin
         if (sel_width)
         begin
            area_bus_width_control <= wb_dat_i[7:0]; // [R6]
         end
         if (sel_state)
         begin
            area_access_state_control <= wb_dat_i[7:0];
         end
         if (sel_wait)
         begin
            upper_areas_wait_control <= wb_dat_i[7:0]; // [R10]
         end
      end
   end

   // Checks of the cycle shapes.
   sequence two_state_walk;
      state == ext_bus_pkg::ST_T1 ##1 state == ext_bus_pkg::ST_T2;
   endsequence

   sequence prog_wait_walk;
      state == ext_bus_pkg::ST_TW ##1 state == ext_bus_pkg::ST_TW;
   endsequence

   as_in_cycle_a: // [R1]
      assert property (@(posedge clk_i) disable iff (rst_i)
         (state != ext_bus_pkg::ST_IDLE) |-> (!addr_valid_strobe_n_o
         && (state == ext_bus_pkg::ST_T1 || $stable(ext_addr_o))))
      else $error("Address strobe not low, or address moved, during an external cycle.");

   rd_read_only_a: // [R2]
      assert property (@(posedge clk_i) disable iff (rst_i)
         !read_strobe_n_o |-> (!we_q && ext_data_oe_n_o))
      else $error("Read strobe active outside a read.");

   upper_lane_write_a: // [R3]
      assert property (@(posedge clk_i) disable iff (rst_i)
         (write_phase && size16_q && !width8_q) |-> !upper_byte_write_strobe_n_o)
      else $error("Upper write strobe missing on a word write.");

   lower_lane_write_a: // [R4]
      assert property (@(posedge clk_i) disable iff (rst_i)
         !lower_byte_write_strobe_n_o |-> (!width8_q && we_q && !ext_data_oe_n_o))
      else $error("Lower write strobe on an eight-bit area or non-write.");

   wait_holds_a: // [R5]
      assert property (@(posedge clk_i) disable iff (rst_i)
         (state == ext_bus_pkg::ST_TW && pw_cnt == 2'h0 && wait_req)
         |=> state == ext_bus_pkg::ST_TW)
      else $error("Wait request did not extend the cycle.");

   two_state_len_a: // [R8]
      assert property (@(posedge clk_i) disable iff (rst_i)
         (take_req && !dec_three) |=> two_state_walk ##1 state != ext_bus_pkg::ST_TW)
      else $error("Two-state area cycle has wrong length.");

   no_waits_two_a: // [R12]
      assert property (@(posedge clk_i) disable iff (rst_i)
         (state == ext_bus_pkg::ST_T2 && !three_q) |=> state != ext_bus_pkg::ST_TW)
      else $error("Wait state in a two-state area.");

   three_state_len_a: // [R9]
      assert property (@(posedge clk_i) disable iff (rst_i)
         (take_req && dec_three) |=> two_state_walk ##1
         (state == ext_bus_pkg::ST_TW || state == ext_bus_pkg::ST_T3))
      else $error("Three-state area cycle lacks its third state.");

   prog_wait_count_a: // [R11]
      assert property (@(posedge clk_i) disable iff (rst_i)
         (state == ext_bus_pkg::ST_T2 && three_q && pw_cnt == 2'h2) |=> prog_wait_walk)
      else $error("Program wait count not honoured.");

   width_split_a: // [R7]
      assert property (@(posedge clk_i) disable iff (rst_i)
         (take_req && req_size16_i && dec_width8 && !dec_three)
         |=> two_state_walk ##1 (state == ext_bus_pkg::ST_T1 && second_q))
      else $error("Word access to an eight-bit area not split.");

endmodule : external_area_bus_config
`default_nettype wire

// >>> testbench/ext_mem_model.sv
// Purpose: External memory and wait source that sits on the external bus pins.
// Assumes: Byte store; an 8-bit device sits on the upper lane and sees every address.
// Notes: While the controller neither reads nor drives them, the data pins show a pattern that changes every cycle.
`timescale 1ns/10ps
`default_nettype none

module ext_mem_model
(
   input wire logic clk_i,
   input wire logic [7:0] width8_map_i,
   input wire logic [3:0] wait_cycles_i,
   input wire logic [23:0] addr_i,
   input wire logic [15:0] dev_data_i,
   input wire logic dev_oe_n_i,
   input wire logic as_n_i,
   input wire logic rd_n_i,
   input wire logic hw_n_i,
   input wire logic lw_n_i,
   output logic wait_n_o,
   output logic [15:0] bus_o
);
   logic [7:0] mem [int];
   logic [15:0] rd_val = 16'h5A5A;
   logic [3:0] wait_left = 4'h0;
   logic as_was_n = 1'b1;
   int up_a;
   int lo_a;

   function automatic logic [7:0] peek(input int a);
      return mem.exists(a) ? mem[a] : 8'hA5;
   endfunction : peek

   // A 16-bit device ignores address bit 0 on its upper lane.
   assign up_a = width8_map_i[addr_i[23:21]] ? int'(addr_i) : int'({addr_i[23:1], 1'b0});
   assign lo_a = int'({addr_i[23:1], 1'b1});
   // The wire carries the device's data while it drives, ours otherwise.
   assign bus_o = dev_oe_n_i ? rd_val : dev_data_i;
   // A slow device is not ready until a cycle has run down its count; the pin crosses
   // two flops in the controller, so it must already be low when the cycle opens.
   assign wait_n_o = (wait_cycles_i == 4'h0) || (!as_n_i && !as_was_n && wait_left == 4'h0);

   // Store strobed lanes, answer reads, and hold the cycle off when told to.
   always @(posedge clk_i)
   begin
      if (!hw_n_i) mem[up_a] = dev_data_i[15:8];
      if (!lw_n_i) mem[lo_a] = dev_data_i[7:0];
      rd_val <= !rd_n_i ? {peek(up_a), peek(lo_a)} : ~rd_val;
      if (as_was_n && !as_n_i) wait_left <= wait_cycles_i;
      else if (wait_left != 4'h0) wait_left <= wait_left - 4'h1;
      as_was_n <= as_n_i;
   end
endmodule : ext_mem_model

`default_nettype wire

// >>> testbench/external_area_bus_config_tb_top.sv
// Purpose: Self-checking bench for the external bus sequencer and its area registers.
// Assumes: Latencies follow the hand-over walk; a shift register from 58 supplies data.
// Notes: Strobe activity is counted per access, so a lane mix-up shows at once.
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_params.svh"

module external_area_bus_config_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic req_valid_i = 1'b0;
   logic req_we_i = 1'b0;
   logic req_size16_i = 1'b0;
   logic [23:0] req_addr_i = 24'h0;
   logic [15:0] req_wdata_i = 16'h0;
   logic [7:0] width_map = 8'hFF;
   logic [3:0] wait_k = 4'h0;
   logic [7:0] rnd = 8'h3A;
   logic [31:0] wb_dat_o;
   logic [15:0] req_rdata_o, ext_data_o, bus;
   logic [23:0] ext_addr_o;
   logic wb_ack_o, req_ready_o, req_done_o, ext_data_oe_n_o, wait_n;
   logic addr_valid_strobe_n_o, read_strobe_n_o;
   logic upper_byte_write_strobe_n_o, lower_byte_write_strobe_n_o;
   int miscompares = 0;
   int checks_done = 0;
   int as_cnt, rd_cnt, hw_cnt, lw_cnt;

   external_area_bus_config uut
   (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .req_valid_i, .req_we_i, .req_size16_i, .req_addr_i,
      .req_wdata_i, .req_ready_o, .req_done_o, .req_rdata_o, .ext_addr_o, .ext_data_o,
      .ext_data_i(bus), .ext_data_oe_n_o, .addr_valid_strobe_n_o, .read_strobe_n_o,
      .upper_byte_write_strobe_n_o, .lower_byte_write_strobe_n_o, .wait_request_n_i(wait_n)
   );

   ext_mem_model mem
   (
      .clk_i, .width8_map_i(width_map), .wait_cycles_i(wait_k), .addr_i(ext_addr_o),
      .dev_data_i(ext_data_o), .dev_oe_n_i(ext_data_oe_n_o), .as_n_i(addr_valid_strobe_n_o),
      .rd_n_i(read_strobe_n_o), .hw_n_i(upper_byte_write_strobe_n_o),
      .lw_n_i(lower_byte_write_strobe_n_o), .wait_n_o(wait_n), .bus_o(bus)
   );

   // Half period of 25 ns gives the 20 MHz clock.
   always #25 clk_i = ~clk_i;

   // Strobe cycles are counted so each access can be judged after it ends.
   always @(posedge clk_i)
   begin
      if (addr_valid_strobe_n_o === 1'b0) as_cnt++;
      if (read_strobe_n_o === 1'b0) rd_cnt++;
      if (upper_byte_write_strobe_n_o === 1'b0) hw_cnt++;
      if (lower_byte_write_strobe_n_o === 1'b0) lw_cnt++;
   end

   function automatic logic [7:0] next_rand();
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      return rnd;
   endfunction : next_rand

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                     input logic [7:0] d, output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic cfg(input logic [7:0] wm, input logic [7:0] sm, input logic [7:0] wt);
      logic [31:0] q;
      width_map <= wm;
      wb(1'b1, `EAB_OFS_WIDTH, 4'hF, wm, q);
      wb(1'b1, `EAB_OFS_STATE, 4'hF, sm, q);
      wb(1'b1, `EAB_OFS_WAIT, 4'hF, wt, q);
   endtask : cfg

   // Latency counts edges from the taking edge to the edge that sees done.
   task automatic ext(input logic we, input logic s16, input logic [23:0] a,
                      input logic [15:0] d, output int lat, output logic [15:0] q);
      as_cnt = 0;
      rd_cnt = 0;
      hw_cnt = 0;
      lw_cnt = 0;
      req_valid_i <= 1'b1;
      req_we_i <= we;
      req_size16_i <= s16;
      req_addr_i <= a;
      req_wdata_i <= d;
      do @(posedge clk_i); while (req_ready_o !== 1'b1);
      req_valid_i <= 1'b0;
      lat = 0;
      do
      begin
         @(posedge clk_i);
         lat++;
      end
      while (req_done_o !== 1'b1 && lat < 60);
      q = req_rdata_o;
   endtask : ext

   initial
   begin
      int areas[5] = '{0, 4, 5, 6, 7};
      logic [7:0] rst_v[3] = '{`EAB_RST_WIDTH, `EAB_RST_STATE, `EAB_RST_WAIT};
      logic [31:0] q;
      logic [15:0] r, d;
      logic [23:0] a;
      logic [7:0] v, wm, sm, wt;
      logic up;
      int ar, n, lat;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 3; i++)
      begin
         wb(1'b0, 4'(i * 4), 4'hF, 8'h00, q);
         check(q, {24'h0, rst_v[i]});
      end
      // A write without the low byte lane enabled must leave the register alone.
      wb(1'b1, `EAB_OFS_STATE, 4'hE, 8'h00, q);
      wb(1'b0, `EAB_OFS_STATE, 4'hF, 8'h00, q);
      check(q, {24'h0, `EAB_RST_STATE});
      // Every state mode and wait code for the wait-field areas and one lower area.
      foreach (areas[k])
         for (int st = 0; st < 2; st++)
            for (int w = 0; w < 4; w++)
            begin
               ar = areas[k];
               wm = next_rand();
               sm = next_rand();
               sm[ar] = st[0];
               wt = next_rand();
               if (ar >= 4) wt[2 * (ar - 4) +: 2] = w[1:0];
               cfg(wm, sm, wt);
               n = (st == 0) ? 0 : (ar < 4) ? 3 : w;
               v = next_rand();
               a = {ar[2:0], 17'h0, v[3:0]};
               up = wm[ar] | ~a[0];
               ext(1'b1, 1'b0, a, {v, v}, lat, r);
               check(lat, (st == 0) ? 4 : 5 + n);
               check(as_cnt, (st == 0) ? 2 : 3 + n);
               check({rd_cnt > 0, hw_cnt > 0, lw_cnt > 0}, {1'b0, up, ~up});
               ext(1'b0, 1'b0, a, 16'h0, lat, r);
               check(r, {8'h00, v});
               check({rd_cnt > 0, hw_cnt > 0, lw_cnt > 0}, 3'b100);
            end
      // The wait pin extends only three-state cycles, and only after program waits.
      wait_k <= 4'h6;
      for (int st = 0; st < 2; st++)
         for (int w = 0; w < 4; w += 2)
         begin
            cfg(8'h00, st[0] ? 8'h20 : 8'h00, {4'h0, w[1:0], 2'b00});
            ext(1'b1, 1'b1, {3'd5, 21'h0}, 16'h1234, lat, r);
            if (st == 0) check(lat, 4);
            else check((lat > 5 + w) && (lat <= 14 + w), 1);
         end
      wait_k <= 4'h0;
      wb(1'b0, `EAB_OFS_STATUS, 4'hF, 8'h00, q);
      check(q & 32'h9F, 32'h15);
      // Words to a sixteen-bit and to an eight-bit area, written and read back.
      for (int i = 0; i < 2; i++)
      begin
         wm = i[0] ? 8'hFF : 8'h00;
         cfg(wm, 8'h00, 8'h00);
         wb(1'b0, `EAB_OFS_WIDTH, 4'hF, 8'h00, q);
         check(q, {24'h0, wm});
         d = {next_rand(), next_rand()};
         a = {3'd6, 17'h0, d[3:1], 1'b0};
         ext(1'b1, 1'b1, a, d, lat, r);
         check(as_cnt, i[0] ? 4 : 2);
         check({hw_cnt > 0, lw_cnt > 0}, {1'b1, ~i[0]});
         ext(1'b0, 1'b1, a, 16'h0, lat, r);
         check(r, d);
      end
      summarize();
   end

   // Cuts a hang short well beyond the thousand or so cycles the sequence needs.
   initial
   begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      summarize();
   end
endmodule : external_area_bus_config_tb_top

`default_nettype wire
